// *** logic/etls_top.sv ***
// external torque limit selector: settings, contact inputs, torque clamp
`include "etls_params.svh"
`default_nettype none

module etls_top
(
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    input wire logic [7:0] TERM_I,
    input wire logic [11:0] TORQUE_REF_I,
    output logic [11:0] TORQUE_CMD_O,
    output logic [9:0] FWD_LIMIT_O,
    output logic [9:0] REV_LIMIT_O,
    output logic LIMIT_ACTIVE_O,
    output logic IRQ_O
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic etls_pkg::etls_pct_t pct_min(
        input etls_pkg::etls_pct_t a,
        input etls_pkg::etls_pct_t b
    );
        pct_min = (a < b) ? a : b;
    endfunction : pct_min

    // settings above the range saturate instead of wrapping
    function automatic etls_pkg::etls_pct_t pct_sat(input logic [31:0] v);
        pct_sat = (v > {22'h000000, `ETLS_LIM_MAX}) ? `ETLS_LIM_MAX
                                                   : v[`ETLS_PCT_W-1:0];
    endfunction : pct_sat

    // select values with the top bit set mean "not assigned"
    function automatic logic term_pick(
        input logic [7:0] terms,
        input etls_pkg::etls_sel_t sel
    );
        term_pick = ~sel[3] & terms[sel[2:0]];
    endfunction : term_pick

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    etls_pkg::etls_pct_t fwd_internal_limit_q;
    etls_pkg::etls_pct_t rev_internal_limit_q;
    etls_pkg::etls_pct_t fwd_external_limit_q;
    etls_pkg::etls_pct_t rev_external_limit_q;
    etls_pkg::etls_pct_t motor_max_q;
    logic [7:0] input_terminal_assign_q;
    etls_pkg::etls_ev_t irq_stat_q;
    etls_pkg::etls_ev_t irq_stat_d;
    etls_pkg::etls_ev_t irq_mask_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire logic hit_fwd_int = (REG_ADDR_I == `ETLS_OFF_FWD_INT);
    wire logic hit_rev_int = (REG_ADDR_I == `ETLS_OFF_REV_INT);
    wire logic hit_fwd_ext = (REG_ADDR_I == `ETLS_OFF_FWD_EXT);
    wire logic hit_rev_ext = (REG_ADDR_I == `ETLS_OFF_REV_EXT);
    wire logic hit_assign = (REG_ADDR_I == `ETLS_OFF_ASSIGN);
    wire logic hit_motor_max = (REG_ADDR_I == `ETLS_OFF_MOTOR_MAX);
    wire logic hit_status = (REG_ADDR_I == `ETLS_OFF_STATUS);
    wire logic hit_irq_stat = (REG_ADDR_I == `ETLS_OFF_IRQ_STAT);
    wire logic hit_irq_mask = (REG_ADDR_I == `ETLS_OFF_IRQ_MASK);

    wire logic irq_read_clr = REG_RD_I & hit_irq_stat;
    wire etls_pkg::etls_pct_t wr_pct = pct_sat(REG_WDATA_I);

    // ------------------------------------------------------------------
    // settings registers
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            fwd_internal_limit_q <= `ETLS_RST_INT_LIM;
            rev_internal_limit_q <= `ETLS_RST_INT_LIM;
            fwd_external_limit_q <= `ETLS_RST_EXT_LIM;
            rev_external_limit_q <= `ETLS_RST_EXT_LIM;
            motor_max_q <= `ETLS_RST_MOTOR_MAX;
            input_terminal_assign_q <= `ETLS_RST_ASSIGN;
            irq_mask_q <= `ETLS_RST_IRQ_MASK;
        end
        else if (REG_WR_I)
        begin
            // new settings act from the next cycle on
            if (hit_fwd_int)
            begin
                fwd_internal_limit_q <= wr_pct;
            end
            if (hit_rev_int)
            begin
                rev_internal_limit_q <= wr_pct;
            end
            if (hit_fwd_ext)
            begin
                fwd_external_limit_q <= wr_pct;
            end
            if (hit_rev_ext)
            begin
                rev_external_limit_q <= wr_pct;
            end
            if (hit_motor_max)
            begin
                motor_max_q <= wr_pct;
            end
            if (hit_assign)
            begin
                input_terminal_assign_q <= REG_WDATA_I[7:0];
            end
            if (hit_irq_mask)
            begin
                irq_mask_q <= REG_WDATA_I[`ETLS_EV_N-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // contact inputs
    // ------------------------------------------------------------------
    logic [7:0] term_sync;

    etls_sync #(
        .WIDTH(`ETLS_TERM_N)
    ) u_sync (
        .MCLK_I(MCLK_I),
        .SYS_RST_I(SYS_RST_I),
        .async_i(TERM_I),
        .sync_o(term_sync)
    );

    wire etls_pkg::etls_sel_t fwd_sel =
        input_terminal_assign_q[`ETLS_ASG_FWD_LSB +: `ETLS_ASG_W];
    wire etls_pkg::etls_sel_t rev_sel =
        input_terminal_assign_q[`ETLS_ASG_REV_LSB +: `ETLS_ASG_W];

    // an unassigned contact reads as open
    wire logic fwd_ext_limit_in = term_pick(term_sync, fwd_sel);
    wire logic rev_ext_limit_in = term_pick(term_sync, rev_sel);

    // ------------------------------------------------------------------
    // limit selection
    // ------------------------------------------------------------------
    wire etls_pkg::etls_pct_t fwd_sel_lim = fwd_ext_limit_in
        ? pct_min(fwd_internal_limit_q, fwd_external_limit_q)
        : fwd_internal_limit_q;
    wire etls_pkg::etls_pct_t rev_sel_lim = rev_ext_limit_in
        ? pct_min(rev_internal_limit_q, rev_external_limit_q)
        : rev_internal_limit_q;

    // the motor cannot exceed its own peak whatever the settings say
    wire etls_pkg::etls_pct_t fwd_lim = pct_min(fwd_sel_lim, motor_max_q);
    wire etls_pkg::etls_pct_t rev_lim = pct_min(rev_sel_lim, motor_max_q);

    // ------------------------------------------------------------------
    // torque clamp
    // ------------------------------------------------------------------
    wire etls_pkg::etls_trq_t trq_ref = TORQUE_REF_I;
    wire logic dir_rev = trq_ref[`ETLS_TRQ_W-1];
    wire logic dir_fwd = ~dir_rev & (trq_ref != 12'sh000);
    // unsigned magnitude keeps the most negative code correct
    wire etls_pkg::etls_mag_t trq_mag = dir_rev ? 12'(~TORQUE_REF_I + 12'h001)
                                                : TORQUE_REF_I;
    wire etls_pkg::etls_mag_t fwd_lim_w = {2'b00, fwd_lim};
    wire etls_pkg::etls_mag_t rev_lim_w = {2'b00, rev_lim};
    wire logic fwd_over = dir_fwd & (trq_mag > fwd_lim_w);
    wire logic rev_over = dir_rev & (trq_mag > rev_lim_w);
    wire logic clamp_now = fwd_over | rev_over;

    wire logic [11:0] rev_neg = 12'(~rev_lim_w + 12'h001);
    wire logic [11:0] trq_d = fwd_over ? fwd_lim_w
                            : rev_over ? rev_neg
                            : TORQUE_REF_I;

    logic [11:0] trq_q;
    logic limit_active_out_q;
    etls_pkg::etls_pct_t fwd_lim_q;
    etls_pkg::etls_pct_t rev_lim_q;
    logic fwd_on_q;
    logic rev_on_q;

    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            trq_q <= 12'h000;
            limit_active_out_q <= 1'b0;
            fwd_lim_q <= 10'h000;
            rev_lim_q <= 10'h000;
            fwd_on_q <= 1'b0;
            rev_on_q <= 1'b0;
        end
        else
        begin
            trq_q <= trq_d;
            limit_active_out_q <= clamp_now;
            fwd_lim_q <= fwd_lim;
            rev_lim_q <= rev_lim;
            fwd_on_q <= fwd_ext_limit_in;
            rev_on_q <= rev_ext_limit_in;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------------
    // rising edges of the clamp flag and of each assigned contact
    wire etls_pkg::etls_ev_t ev_set = {
        rev_ext_limit_in & ~rev_on_q,
        fwd_ext_limit_in & ~fwd_on_q,
        clamp_now & ~limit_active_out_q
    };

    // an event landing on the clearing read survives it
    always_comb
    begin
        irq_stat_d = irq_stat_q;
        if (irq_read_clr)
        begin
            irq_stat_d = 3'h0;
        end
        irq_stat_d = irq_stat_d | ev_set;
    end

    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            irq_stat_q <= 3'h0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    wire logic [31:0] status_word = {
        29'h00000000,
        rev_on_q,
        fwd_on_q,
        limit_active_out_q
    };

    always_comb
    begin
        rdata_d = 32'h00000000;
        if (REG_RD_I)
        begin
            if (hit_fwd_int)
            begin
                rdata_d = {22'h000000, fwd_internal_limit_q};
            end
            else if (hit_rev_int)
            begin
                rdata_d = {22'h000000, rev_internal_limit_q};
            end
            else if (hit_fwd_ext)
            begin
                rdata_d = {22'h000000, fwd_external_limit_q};
            end
            else if (hit_rev_ext)
            begin
                rdata_d = {22'h000000, rev_external_limit_q};
            end
            else if (hit_assign)
            begin
                rdata_d = {24'h000000, input_terminal_assign_q};
            end
            else if (hit_motor_max)
            begin
                rdata_d = {22'h000000, motor_max_q};
            end
            else if (hit_status)
            begin
                rdata_d = status_word;
            end
            else if (hit_irq_stat)
            begin
                rdata_d = {29'h00000000, irq_stat_q};
            end
            else if (hit_irq_mask)
            begin
                rdata_d = {29'h00000000, irq_mask_q};
            end
        end
    end

    // read data stand for exactly one cycle, zero otherwise
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            rdata_q <= 32'h00000000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign REG_RDATA_O = rdata_q;
    assign TORQUE_CMD_O = trq_q;
    assign FWD_LIMIT_O = fwd_lim_q;
    assign REV_LIMIT_O = rev_lim_q;
    assign LIMIT_ACTIVE_O = limit_active_out_q;
    assign IRQ_O = |(irq_stat_q & irq_mask_q);

endmodule : etls_top

`default_nettype wire

// *** logic/etls_params.svh ***
// constants for the external torque limit selector
`ifndef ETLS_PARAMS_SVH
`define ETLS_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define ETLS_OFF_FWD_INT 8'h00
`define ETLS_OFF_REV_INT 8'h04
`define ETLS_OFF_FWD_EXT 8'h08
`define ETLS_OFF_REV_EXT 8'h0c
`define ETLS_OFF_ASSIGN 8'h10
`define ETLS_OFF_MOTOR_MAX 8'h14
`define ETLS_OFF_STATUS 8'h18
`define ETLS_OFF_IRQ_STAT 8'h1c
`define ETLS_OFF_IRQ_MASK 8'h20

// ----------------------------------------------------------------------
// reset values and ranges (percent of rated torque)
// ----------------------------------------------------------------------
`define ETLS_LIM_MAX 10'h320
`define ETLS_RST_INT_LIM 10'h320
`define ETLS_RST_EXT_LIM 10'h064
// arbitrary plain default, software loads the real motor figure
`define ETLS_RST_MOTOR_MAX 10'h12c
`define ETLS_RST_ASSIGN 8'h88
`define ETLS_RST_IRQ_MASK 3'h0

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ETLS_ASG_FWD_LSB 0
`define ETLS_ASG_REV_LSB 4
`define ETLS_ASG_W 4
`define ETLS_TERM_N 8
`define ETLS_EV_LIMIT 0
`define ETLS_EV_FWD 1
`define ETLS_EV_REV 2
`define ETLS_EV_N 3
`define ETLS_PCT_W 10
`define ETLS_TRQ_W 12

`endif

// *** logic/etls_pkg.sv ***
// types of the external torque limit selector
`default_nettype none

package etls_pkg;
    typedef logic [9:0] etls_pct_t;
    typedef logic signed [11:0] etls_trq_t;
    typedef logic [11:0] etls_mag_t;
    typedef logic [2:0] etls_ev_t;
    typedef logic [3:0] etls_sel_t;
endpackage : etls_pkg

`default_nettype wire

// *** logic/etls_sync.sv ***
// two-flop synchroniser for the contact input terminals
`default_nettype none

module etls_sync
#(
    parameter int WIDTH = 8
)
(
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule : etls_sync

`default_nettype wire

// *** dv/etls_checker.sv ***
// assertion checker for the torque limit selector ports
`include "etls_params.svh"
`default_nettype none

module etls_checker
(
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic [7:0] TERM_I,
    input wire logic [11:0] TORQUE_REF_I,
    input wire logic [11:0] TORQUE_CMD_O,
    input wire logic [9:0] FWD_LIMIT_O,
    input wire logic [9:0] REV_LIMIT_O,
    input wire logic LIMIT_ACTIVE_O,
    input wire logic IRQ_O
);
    timeunit 1ns;
    timeprecision 100ps;

    // mask resets to zero, so no interrupt before software writes it
    logic mask_seen_q;
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            mask_seen_q <= 1'b0;
        else if (REG_WR_I && REG_ADDR_I == `ETLS_OFF_IRQ_MASK)
            mask_seen_q <= 1'b1;
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    a_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
        else $error("read data not zero outside read answer");
    a_fwd_bound: assert property (!$past(SYS_RST_I) |->
        $signed(TORQUE_CMD_O) <= $signed({2'b00, FWD_LIMIT_O}))
        else $error("forward torque above limit");
    a_rev_bound: assert property (!$past(SYS_RST_I) |->
        $signed(TORQUE_CMD_O) >= -$signed({2'b00, REV_LIMIT_O}))
        else $error("reverse torque above limit");
    a_active_at_limit: assert property (LIMIT_ACTIVE_O |->
        TORQUE_CMD_O == {2'b00, FWD_LIMIT_O} || TORQUE_CMD_O == 12'h000 - {2'b00, REV_LIMIT_O})
        else $error("active flag without torque at a limit");
    a_pass_through: assert property (!$past(SYS_RST_I) && !LIMIT_ACTIVE_O |->
        TORQUE_CMD_O == $past(TORQUE_REF_I))
        else $error("unclamped torque differs from request");
    a_active_cause: assert property (LIMIT_ACTIVE_O |-> TORQUE_CMD_O != $past(TORQUE_REF_I))
        else $error("active flag while request passes unchanged");
    a_limit_range: assert property (FWD_LIMIT_O <= `ETLS_LIM_MAX && REV_LIMIT_O <= `ETLS_LIM_MAX)
        else $error("effective limit above range");
    a_limit_steady: assert property ((!REG_WR_I && $stable(TERM_I))[*4] |=>
        $stable(FWD_LIMIT_O) && $stable(REV_LIMIT_O))
        else $error("limit moved without a cause");
    a_irq_masked: assert property (!mask_seen_q |-> !IRQ_O)
        else $error("interrupt with mask at reset value");

    c_clamp: cover property ($rose(LIMIT_ACTIVE_O));
    c_irq: cover property ($rose(IRQ_O));
    c_read: cover property (REG_RD_I ##1 REG_RDATA_O != 32'h0);
endmodule : etls_checker

bind etls_top etls_checker u_chk (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .TERM_I(TERM_I),
    .TORQUE_REF_I(TORQUE_REF_I), .TORQUE_CMD_O(TORQUE_CMD_O), .FWD_LIMIT_O(FWD_LIMIT_O),
    .REV_LIMIT_O(REV_LIMIT_O), .LIMIT_ACTIVE_O(LIMIT_ACTIVE_O), .IRQ_O(IRQ_O));

`default_nettype wire

// *** dv/etls_ctrl_model.sv ***
// upper controller model closing the limit contacts
`default_nettype none

module etls_ctrl_model
#(
    parameter int FWD_TERM = 0,
    parameter int REV_TERM = 1
)
(
    input wire logic clk_i,
    input wire logic fwd_req_i,
    input wire logic rev_req_i,
    output logic [7:0] term_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // unused terminals are open contacts, a defined level
    logic [7:0] term_q = 8'h00;

    always @(posedge clk_i)
    begin
        term_q[FWD_TERM] <= fwd_req_i;
        term_q[REV_TERM] <= rev_req_i;
    end

    assign term_o = term_q;
endmodule : etls_ctrl_model

`default_nettype wire

// *** dv/tb_external_torque_limit_select.sv ***
// self-checking bench for the torque limit selector
`default_nettype none

module tb_external_torque_limit_select;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [11:0] tref = 12'h000;
    logic fwd_req = 1'b0;
    logic rev_req = 1'b0;
    logic [31:0] rdata;
    logic [7:0] term;
    logic [11:0] tcmd;
    logic [9:0] flim;
    logic [9:0] rlim;
    logic act;
    logic irq;
    int mismatches = 0;
    int num_checks = 0;

    etls_top dut (.MCLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .TERM_I(term),
        .TORQUE_REF_I(tref), .TORQUE_CMD_O(tcmd), .FWD_LIMIT_O(flim), .REV_LIMIT_O(rlim),
        .LIMIT_ACTIVE_O(act), .IRQ_O(irq));
    etls_ctrl_model #(.FWD_TERM(0), .REV_TERM(1)) u_ctrl (.clk_i(clk), .fwd_req_i(fwd_req),
        .rev_req_i(rev_req), .term_o(term));

    initial forever #2.5 clk = ~clk;

    // ------------------------------------------------------------------
    // bus, compare and closing tasks
    // ------------------------------------------------------------------
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: reg %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_out(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: out %h exp %h", $time, got, exp);
        end
    endtask : chk_out

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_reg(rdata, exp);
    endtask : rd_chk

    // new request, then let the sync and output registers settle
    task automatic step(input logic [11:0] r, input int n);
        @(posedge clk);
        tref <= r;
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] a[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24};
        logic [31:0] e[8] = '{32'h320, 32'h320, 32'h64, 32'h64, 32'h88, 32'h12c, 32'h0, 32'h0};
        for (int i = 0; i < 8; i++)
            rd_chk(a[i], e[i]);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_clamp;
        step(12'h384, 2);
        chk_out(tcmd, 12'h12c);
        chk_out({11'h0, act}, 12'h001);
        rd_chk(8'h1c, 32'h1);
        rd_chk(8'h1c, 32'h0);
        step(12'hfce, 2);
        chk_out(tcmd, 12'hfce);
        chk_out({11'h0, act}, 12'h000);
        $display("t_clamp done");
    endtask : t_clamp

    task automatic t_select;
        wr_reg(8'h14, 32'h320);
        wr_reg(8'h08, 32'h32);
        wr_reg(8'h0c, 32'h46);
        fwd_req <= 1'b1;
        rev_req <= 1'b1;
        step(12'h000, 6);
        chk_out({2'b00, flim}, 12'h320);
        wr_reg(8'h10, 32'h10);
        step(12'h000, 3);
        chk_out({2'b00, flim}, 12'h032);
        chk_out({2'b00, rlim}, 12'h046);
        rd_chk(8'h18, 32'h6);
        step(12'h384, 2);
        chk_out(tcmd, 12'h032);
        step(12'hc7c, 2);
        chk_out(tcmd, 12'hfba);
        wr_reg(8'h08, 32'h3e8);
        rd_chk(8'h08, 32'h320);
        wr_reg(8'h00, 32'hc8);
        step(12'h000, 2);
        chk_out({2'b00, flim}, 12'h0c8);
        // a low external setting makes the open-contact check telling
        wr_reg(8'h08, 32'h32);
        fwd_req <= 1'b0;
        rev_req <= 1'b0;
        step(12'h000, 6);
        chk_out({2'b00, flim}, 12'h0c8);
        chk_out({2'b00, rlim}, 12'h320);
        $display("t_select done");
    endtask : t_select

    task automatic t_irq;
        rd_chk(8'h1c, 32'h7);
        wr_reg(8'h20, 32'h1);
        step(12'h384, 2);
        chk_out({11'h0, irq}, 12'h001);
        rd_chk(8'h1c, 32'h1);
        chk_out({11'h0, irq}, 12'h000);
        step(12'h000, 2);
        $display("t_irq done");
    endtask : t_irq

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_clamp;
        t_select;
        t_irq;
        test_done;
    end

    initial
    begin
        #20us;
        mismatches++;
        test_done;
    end
endmodule : tb_external_torque_limit_select

`default_nettype wire
